// *** verilog/rxqpt_regs.sv ***
/*
  receive queue pointer, auto-increment, sample time, byte order and
  the two receive interrupt thresholds (duration, byte count).
  assumes a host interface decoder ahead of it that presents single
  cycle register strobes and data register access pulses.
*/
`timescale 1ns/1ps
module rxqpt_regs
  import rxqpt_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire rxqpt_reg_req_t reg_req, // register access strobe
  output logic [15:0] reg_rdata, // read data, registered
  input wire rxqpt_data_acc_t data_acc, // frame data register access
  input wire logic byte_order_strap, // strap level at reset
  input wire logic [15:0] receive_queue_control, // queue control reg
  input wire logic [15:0] rx_bytes_held, // bytes in receive queue
  input wire logic [15:0] rx_frames_held, // frames in receive queue
  input wire logic rx_flag_clear, // host write-one to status bit
  output logic [10:0] rx_buffer_pointer, // buffer byte address
  output logic write_sample_time_select, // write data sample time
  output logic byte_order_select, // 1 big endian
  output logic rx_event_flag // receive interrupt status
);

  logic rx_pointer_auto_step; // auto-step enable
  logic [15:0] rx_duration_limit; // duration threshold, microseconds
  logic [15:0] rx_byte_limit; // byte count threshold
  logic strap_taken; // strap captured after reset release
  logic [4:0] tick_cnt; // microsecond prescaler
  logic us_tick; // one-cycle microsecond enable
  logic [16:0] dur_cnt; // elapsed microseconds since first frame
  logic dur_run; // timer running
  logic dur_hit; // duration over limit
  logic byte_hit; // bytes over limit
  logic hit_any; // either threshold source
  logic hit_prev; // previous source level for edge set
  logic wr_ptr; // write to pointer control
  logic [10:0] next_pointer; // pointer after an access

  // step size of one data register access
  function automatic logic [10:0] rxqpt_step(input rxqpt_size_t sz);
    case (sz)
      RXQPT_SZ_WORD: rxqpt_step = 11'h002;
      RXQPT_SZ_DWORD: rxqpt_step = 11'h004;
      default: rxqpt_step = 11'h001;
    endcase
  endfunction : rxqpt_step

  assign wr_ptr = reg_req.wr && (reg_req.addr == RXQPT_OFS_PTR);

  // pointer next value
  always_comb begin
    next_pointer = rx_buffer_pointer;
    if (wr_ptr) begin
      // host positions the pointer directly
      next_pointer = reg_req.wdata[RXQPT_PTR_W-1:0];
    end else if (data_acc.valid && rx_pointer_auto_step) begin
      next_pointer = 11'(rx_buffer_pointer +
                         rxqpt_step(data_acc.size));
    end
    // with auto-step off a data access keeps the pointer
  end

  // pointer register, wraps within the 2 KB buffer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_buffer_pointer <= RXQPT_PTR_RST;
    end else begin
      rx_buffer_pointer <= next_pointer;
    end
  end

  // control bits of the pointer register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_pointer_auto_step <= 1'b0;
      write_sample_time_select <= RXQPT_WST_RST;
    end else if (wr_ptr) begin
      rx_pointer_auto_step <= reg_req.wdata[RXQPT_AUTO_BIT];
      write_sample_time_select <= reg_req.wdata[RXQPT_WST_BIT];
    end
  end

  // byte order caught from the strap on the first clock after reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_taken <= 1'b0;
      byte_order_select <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      byte_order_select <= byte_order_strap;
    end else if (wr_ptr) begin
      // host is expected to write back the strapped value
      byte_order_select <= reg_req.wdata[RXQPT_ORDER_BIT];
    end
  end

  // threshold registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_duration_limit <= RXQPT_THR_RST;
      rx_byte_limit <= RXQPT_THR_RST;
    end else if (reg_req.wr) begin
      if (reg_req.addr == RXQPT_OFS_DUR) begin
        rx_duration_limit <= reg_req.wdata;
      end else if (reg_req.addr == RXQPT_OFS_BYTES) begin
        rx_byte_limit <= reg_req.wdata;
      end
    end
  end

  // register read mux, reserved bits read zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_req.rd) begin
      if (reg_req.addr == RXQPT_OFS_PTR) begin
        reg_rdata <= {1'b0, rx_pointer_auto_step, 1'b0,
                      write_sample_time_select, byte_order_select,
                      rx_buffer_pointer};
      end else if (reg_req.addr == RXQPT_OFS_DUR) begin
        reg_rdata <= rx_duration_limit;
      end else if (reg_req.addr == RXQPT_OFS_BYTES) begin
        reg_rdata <= rx_byte_limit;
      end else begin
        reg_rdata <= 16'h0000; // unmapped reads zero
      end
    end
  end

  // microsecond tick prescaler, free running
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= 5'h00;
    end else if (tick_cnt == 5'(RXQPT_TICK_CYC - 1)) begin
      tick_cnt <= 5'h00;
    end else begin
      tick_cnt <= tick_cnt + 5'h01;
    end
  end
  assign us_tick = (tick_cnt == 5'(RXQPT_TICK_CYC - 1));

  // duration timer: starts on first frame, clears when queue empties
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dur_run <= 1'b0;
      dur_cnt <= 17'h00000;
    end else if (rx_frames_held == 16'h0000) begin
      dur_run <= 1'b0;
      dur_cnt <= 17'h00000;
    end else begin
      dur_run <= 1'b1;
      if (dur_run && us_tick && !dur_cnt[16]) begin
        dur_cnt <= dur_cnt + 17'h00001;
      end
    end
  end

  assign dur_hit = receive_queue_control[RXQPT_QC_DUR_EN] && dur_run &&
                   (dur_cnt > {1'b0, rx_duration_limit});
  assign byte_hit = receive_queue_control[RXQPT_QC_BYTE_EN] &&
                    (rx_bytes_held > rx_byte_limit);
  assign hit_any = dur_hit || byte_hit;

  // edge-set receive flag; a new edge wins over a clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hit_prev <= 1'b0;
      rx_event_flag <= 1'b0;
    end else begin
      hit_prev <= hit_any;
      if (hit_any && !hit_prev) begin
        rx_event_flag <= 1'b1;
      end else if (rx_flag_clear) begin
        rx_event_flag <= 1'b0;
      end
    end
  end

  // assertions
  a_auto_step_size: assert property (@(posedge core_clk) disable iff (rst)
    data_acc.valid && rx_pointer_auto_step && !wr_ptr |=>
      rx_buffer_pointer == 11'($past(rx_buffer_pointer) +
        rxqpt_step($past(data_acc.size))))
    else $error("pointer step wrong");

  a_pointer_hold: assert property (@(posedge core_clk) disable iff (rst)
    !rx_pointer_auto_step && !wr_ptr |=>
      $stable(rx_buffer_pointer))
    else $error("pointer moved without auto-step");

  a_pointer_write: assert property (@(posedge core_clk) disable iff (rst)
    wr_ptr |=> rx_buffer_pointer == $past(reg_req.wdata[10:0]))
    else $error("pointer write lost");

  a_wst_write: assert property (@(posedge core_clk) disable iff (rst)
    wr_ptr |=> write_sample_time_select == $past(reg_req.wdata[12]))
    else $error("sample time bit not written");

  a_strap_load: assert property (@(posedge core_clk) disable iff (rst)
    !strap_taken |=> byte_order_select == $past(byte_order_strap))
    else $error("strap not captured");

  a_timer_clear: assert property (@(posedge core_clk) disable iff (rst)
    rx_frames_held == 16'h0000 |=> dur_cnt == 17'h00000 && !dur_run)
    else $error("timer not cleared on empty");

  sequence s_rise;
    !hit_prev ##0 hit_any;
  endsequence

  a_flag_set: assert property (@(posedge core_clk) disable iff (rst)
    s_rise |=> rx_event_flag)
    else $error("flag not set on threshold");

  a_flag_sticky: assert property (@(posedge core_clk) disable iff (rst)
    rx_event_flag && !rx_flag_clear |=> rx_event_flag)
    else $error("flag dropped without clear");

  a_flag_clear: assert property (@(posedge core_clk) disable iff (rst)
    rx_event_flag && rx_flag_clear && !(hit_any && !hit_prev)
      |=> !rx_event_flag)
    else $error("flag clear ignored");

  a_byte_thresh: assert property (@(posedge core_clk) disable iff (rst)
    receive_queue_control[RXQPT_QC_BYTE_EN] && !hit_prev &&
      (rx_bytes_held > rx_byte_limit) |=> rx_event_flag)
    else $error("byte threshold missed");

  // no flag without a fresh threshold edge
  a_flag_edge: assert property (@(posedge core_clk) disable iff (rst)
    !rx_event_flag ##1 rx_event_flag |->
      $past(hit_any) && !$past(hit_prev))
    else $error("flag set without threshold edge");

  // any frame held starts the duration timer
  a_timer_start: assert property (@(posedge core_clk) disable iff (rst)
    rx_frames_held != 16'h0000 |=> dur_run)
    else $error("timer not started by frame");

  // duration limit takes the host word
  a_limit_write: assert property (@(posedge core_clk) disable iff (rst)
    reg_req.wr && (reg_req.addr == RXQPT_OFS_DUR) |=>
      rx_duration_limit == $past(reg_req.wdata))
    else $error("duration limit write lost");

endmodule : rxqpt_regs

// *** verilog/rxqpt_pkg.sv ***
/*
  package for the receive queue pointer and threshold register block:
  register offsets, field positions, reset values, timing constants.
  assumes a 16-bit register port with byte offsets as printed.
*/
package rxqpt_pkg;
  // register byte offsets
  localparam logic [8:0] RXQPT_OFS_PTR = 9'h186;
  localparam logic [8:0] RXQPT_OFS_DUR = 9'h18C;
  localparam logic [8:0] RXQPT_OFS_BYTES = 9'h18E;
  // field positions in the pointer control register
  localparam int RXQPT_AUTO_BIT = 14;
  localparam int RXQPT_WST_BIT = 12;
  localparam int RXQPT_ORDER_BIT = 11;
  localparam int RXQPT_PTR_W = 11;
  // receive queue control enable positions
  localparam int RXQPT_QC_DUR_EN = 7;
  localparam int RXQPT_QC_BYTE_EN = 6;
  // reset values and duration maximum
  localparam logic RXQPT_WST_RST = 1'b1;
  localparam logic [15:0] RXQPT_THR_RST = 16'h0000;
  localparam logic [10:0] RXQPT_PTR_RST = 11'h000;
  localparam logic [15:0] RXQPT_DUR_MAX = 16'hCFFF;
  // microsecond tick from the system clock
  localparam int RXQPT_CLK_MHZ = 25;
  localparam int RXQPT_TICK_NS = 1000;
  localparam int RXQPT_CLK_NS = 40;
  localparam int RXQPT_TICK_CYC = RXQPT_TICK_NS / RXQPT_CLK_NS;
  // data access sizes
  typedef enum logic [1:0] {
    RXQPT_SZ_BYTE,
    RXQPT_SZ_WORD,
    RXQPT_SZ_DWORD
  } rxqpt_size_t;
  // one host register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [15:0] wdata;
  } rxqpt_reg_req_t;
  // one access to the frame data register
  typedef struct packed {
    logic valid;
    rxqpt_size_t size;
  } rxqpt_data_acc_t;
endpackage : rxqpt_pkg

// *** sim/rxqpt_host_model.sv ***
/*
  host processor model for the receive pointer and threshold registers:
  single-cycle register writes and reads on the block's strobe port.
  assumes the bench calls its tasks and that inputs move on falling edges.
*/
`timescale 1ns/1ps
module rxqpt_host_model
  import rxqpt_pkg::*;
(
  input wire logic core_clk, // system clock
  input wire logic [15:0] reg_rdata, // registered read data
  output rxqpt_reg_req_t reg_req // register strobe to the block
);
  // idle bus until the first access
  initial reg_req = '0;

  // one write strobe, held across exactly one rising edge
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(negedge core_clk) reg_req <= '{wr:1'b1, rd:1'b0, addr:a, wdata:d};
    @(negedge core_clk) reg_req <= '0;
  endtask : wr

  // one read strobe; data is taken once the answer edge has passed
  task automatic rd(input logic [8:0] a, output logic [15:0] d);
    @(negedge core_clk) reg_req <= '{wr:1'b0, rd:1'b1, addr:a, wdata:16'h0};
    @(negedge core_clk) reg_req <= '0;
    @(negedge core_clk) d = reg_rdata;
  endtask : rd
endmodule : rxqpt_host_model

// *** sim/tb_top.sv ***
/*
  self-checking bench for the receive pointer and threshold registers.
  assumes a 25 MHz clock and a strap level of 1 on the byte order pin,
  then 0 for a second reset late in the run.
*/
`timescale 1ns/1ps
module tb_top
  import rxqpt_pkg::*;
;
  logic core_clk, rst, rx_flag_clear, byte_order_strap;
  logic [15:0] reg_rdata, receive_queue_control, rx_bytes_held;
  logic [15:0] rx_frames_held, d, e;
  rxqpt_reg_req_t reg_req; // host strobes
  rxqpt_data_acc_t data_acc; // frame data accesses
  logic [10:0] rx_buffer_pointer;
  logic write_sample_time_select, byte_order_select, rx_event_flag;
  int errors, checked, i;

  rxqpt_regs rxqpt_regs_i (.core_clk, .rst, .reg_req, .reg_rdata,
    .data_acc, .byte_order_strap, .receive_queue_control, .rx_bytes_held,
    .rx_frames_held, .rx_flag_clear, .rx_buffer_pointer,
    .write_sample_time_select, .byte_order_select, .rx_event_flag);
  rxqpt_host_model host_i (.core_clk, .reg_rdata, .reg_req);

  // 40 ns clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // counts, verdict, end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // one frame data access pulse
  task automatic acc(input rxqpt_size_t s);
    @(negedge core_clk) data_acc <= '{valid:1'b1, size:s};
    @(negedge core_clk) data_acc <= '0;
  endtask : acc

  // bounded wait for the receive flag; running out ends the run
  task automatic wait_flag;
    int n;
    for (n = 0; n < 120 && rx_event_flag !== 1'b1; n++) @(negedge core_clk);
    if (rx_event_flag !== 1'b1) begin
      errors++;
      $display("[ERR] %0t receive flag never rose", $time);
      test_done();
    end
  endtask : wait_flag

  // main sequence
  initial begin
    rst = 1'b1;
    rx_flag_clear = 1'b0;
    byte_order_strap = 1'b1;
    data_acc = '0;
    receive_queue_control = 16'h0000;
    rx_bytes_held = 16'h0000;
    rx_frames_held = 16'h0000;
    repeat (5) @(negedge core_clk);
    check({15'h0, write_sample_time_select}, 16'h0001);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
    check({15'h0, byte_order_select}, 16'h0001);
    host_i.rd(RXQPT_OFS_PTR, d);
    check(d, 16'h1800);
    host_i.rd(RXQPT_OFS_DUR, d);
    check(d, RXQPT_THR_RST);
    host_i.rd(RXQPT_OFS_BYTES, d);
    check(d, RXQPT_THR_RST);
    host_i.rd(9'h188, d); // unmapped place reads zero
    check(d, 16'h0000);
    $display("reset test done");
    // auto-step on, sample time 0, strapped order kept, pointer near top
    host_i.wr(RXQPT_OFS_PTR, 16'h4FFE);
    check({15'h0, write_sample_time_select}, 16'h0000);
    e = 16'h07FE;
    check({5'h0, rx_buffer_pointer}, e);
    for (i = 0; i < 3; i++) begin
      acc(rxqpt_size_t'(i));
      e = (e + (16'h1 << i)) & 16'h07FF;
      check({5'h0, rx_buffer_pointer}, e);
    end
    host_i.rd(RXQPT_OFS_PTR, d);
    check(d, 16'h4800 | e);
    // auto-step off: accesses leave the pointer alone
    host_i.wr(RXQPT_OFS_PTR, 16'h1810);
    acc(RXQPT_SZ_WORD);
    check({5'h0, rx_buffer_pointer}, 16'h0010);
    $display("pointer test done");
    // byte count threshold, strictly greater
    host_i.wr(RXQPT_OFS_BYTES, 16'h0005);
    receive_queue_control = 16'h0040;
    rx_bytes_held = 16'h0005;
    repeat (3) @(negedge core_clk);
    check({15'h0, rx_event_flag}, 16'h0000);
    rx_bytes_held = 16'h0006;
    @(negedge core_clk);
    check({15'h0, rx_event_flag}, 16'h0001);
    host_i.rd(RXQPT_OFS_BYTES, d);
    check({15'h0, rx_event_flag}, 16'h0001);
    rx_flag_clear = 1'b1;
    @(negedge core_clk);
    rx_flag_clear = 1'b0;
    repeat (3) @(negedge core_clk);
    check({15'h0, rx_event_flag}, 16'h0000);
    receive_queue_control = 16'h0000;
    rx_bytes_held = 16'h0000;
    $display("byte threshold test done");
    // duration threshold of 2 us
    host_i.wr(RXQPT_OFS_DUR, 16'h0002);
    host_i.rd(RXQPT_OFS_DUR, d);
    check(d, 16'h0002);
    receive_queue_control = 16'h0080;
    rx_frames_held = 16'h0001;
    repeat (40) @(negedge core_clk);
    check({15'h0, rx_event_flag}, 16'h0000);
    wait_flag();
    check({15'h0, rx_event_flag}, 16'h0001);
    rx_frames_held = 16'h0000;
    rx_flag_clear = 1'b1;
    @(negedge core_clk);
    rx_flag_clear = 1'b0;
    repeat (100) @(negedge core_clk);
    check({15'h0, rx_event_flag}, 16'h0000);
    rx_frames_held = 16'h0001;
    repeat (40) @(negedge core_clk);
    check({15'h0, rx_event_flag}, 16'h0000);
    wait_flag();
    check({15'h0, rx_event_flag}, 16'h0001);
    $display("duration test done");
    // host rewinds the pointer ahead of a buffer read pass
    host_i.wr(RXQPT_OFS_PTR, 16'h1800);
    check({5'h0, rx_buffer_pointer}, {5'h0, RXQPT_PTR_RST});
    // second reset with the strap low: byte order follows the strap
    receive_queue_control = 16'h0000;
    rx_frames_held = 16'h0000;
    host_i.wr(RXQPT_OFS_DUR, 16'h0007);
    byte_order_strap = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    repeat (2) @(negedge core_clk);
    check({15'h0, byte_order_select}, 16'h0000);
    check({15'h0, rx_event_flag}, 16'h0000);
    host_i.rd(RXQPT_OFS_PTR, d);
    check(d, 16'h1000);
    host_i.rd(RXQPT_OFS_DUR, d);
    check(d, RXQPT_THR_RST);
    $display("second reset test done");
    test_done();
  end
endmodule : tb_top
